// file: bench/arf_result_block_sva.sv
// port assertions for the converter result block
`timescale 1ns/1ps
`default_nettype none
module arf_result_block_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic io_space,
    input wire logic [7:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_hit,
    input wire logic conv_busy,
    input wire logic conv_done,
    input wire logic signed [11:0] conv_raw,
    input wire logic conversion_done_flag,
    input wire logic [1:0] active_ref_sel,
    input wire logic [4:0] active_channel_sel,
    input wire logic active_diff_mode,
    input wire logic [9:0] result_code
);
    // =====
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_rdata_idle_zero: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_sel_io_hit: assert property (bus_rd && io_space && bus_addr == 8'h07 |=> bus_hit)
        else $error("selection register missed at short offset");
    a_sel_data_hit: assert property (bus_rd && !io_space && bus_addr == 8'h27 |=> bus_hit)
        else $error("selection register missed at data alias");
    a_io_top_miss: assert property ((bus_rd || bus_wr) && io_space && bus_addr >= 8'h40 |=> !bus_hit)
        else $error("short access above range answered");
    a_ext_data_miss: assert property ((bus_rd || bus_wr) && !io_space && bus_addr >= 8'h60 |=> !bus_hit)
        else $error("extended region answered");
    a_done_two_cyc: assert property (conv_done ##1 !conv_busy [*2] |-> conversion_done_flag)
        else $error("done flag late");
    a_neg_full_sat: assert property (conv_done && active_diff_mode && conv_raw < -512 ##1 active_diff_mode |-> ##1 result_code == 10'h200)
        else $error("negative full scale not saturated");
    a_sel_held_busy: assert property (conv_busy && $past(conv_busy) && $past(conv_busy, 2) && !conv_done && !$past(conv_done)
        |=> $stable(active_ref_sel) && $stable(active_channel_sel))
        else $error("selection changed during conversion");
    c_hit: cover property (bus_hit);
    c_flag: cover property ($rose(conversion_done_flag));
    c_diff: cover property (conv_done && active_diff_mode);
endmodule
bind arf_result_block arf_result_block_sva chk_u (.sys_clk, .rst, .io_space, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
    .bus_rdata, .bus_hit, .conv_busy, .conv_done, .conv_raw, .conversion_done_flag, .active_ref_sel,
    .active_channel_sel, .active_diff_mode, .result_code);
`default_nettype wire

// file: bench/tb_arf_result_block.sv
// self-checking bench for the converter result block
`timescale 1ns/1ps
`default_nettype none
module tb_arf_result_block;
    // =====
    // stimulus and checks
    logic sys_clk = 1'b0, rst = 1'b1, io_space = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
    logic conv_busy = 1'b0, conv_done = 1'b0;
    logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata;
    logic signed [11:0] conv_raw = 12'h000;
    logic bus_hit, conversion_done_flag, active_diff_mode;
    logic [1:0] active_ref_sel;
    logic [4:0] active_channel_sel;
    logic [9:0] result_code;
    int err_count = 0, checks_done = 0, cycles = 0;
    arf_result_block dut_u (.sys_clk, .rst, .io_space, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
        .bus_hit, .conv_busy, .conv_done, .conv_raw, .conversion_done_flag, .active_ref_sel,
        .active_channel_sel, .active_diff_mode, .result_code);
    initial forever #4 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one access; the extra cycle keeps strobes from being re-raised in the same step
    task automatic acc(input logic io, input logic [7:0] a, input logic wr, input logic [7:0] d,
        input logic hit, input logic [7:0] exp);
        io_space = io;
        bus_addr = a;
        bus_wdata = d;
        bus_wr = wr;
        bus_rd = !wr;
        @(negedge sys_clk);
        chk(bus_hit, hit);
        chk(bus_rdata, wr ? 8'h00 : exp);
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic conv(input logic signed [11:0] raw, input logic [9:0] exp);
        conv_busy = 1'b1;
        @(negedge sys_clk);
        conv_busy = 1'b0;
        conv_done = 1'b1;
        conv_raw = raw;
        @(negedge sys_clk);
        conv_done = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk(result_code, exp);
        chk(conversion_done_flag, 1'b1);
    endtask
    task automatic t_regs;
        acc(1'b1, 8'h07, 1'b0, 8'h00, 1'b1, 8'h00);
        acc(1'b1, 8'h07, 1'b1, 8'hED, 1'b1, 8'h00);
        acc(1'b0, 8'h27, 1'b0, 8'h00, 1'b1, 8'hED);
        acc(1'b1, 8'h47, 1'b0, 8'h00, 1'b0, 8'h00);
        acc(1'b0, 8'h07, 1'b0, 8'h00, 1'b0, 8'h00);
        acc(1'b0, 8'h67, 1'b0, 8'h00, 1'b0, 8'h00);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 8'h07, 1'b1, 8'(i * 64 + 8), 1'b1, 8'h00);
            @(negedge sys_clk);
            chk(active_ref_sel, 16'(i));
            chk(active_diff_mode, 1'b1);
        end
        $display("regs test done");
    endtask
    task automatic t_diff;
        acc(1'b1, 8'h07, 1'b1, 8'hED, 1'b1, 8'h00);
        conv(-12'sh190, 10'h270);
        acc(1'b1, 8'h04, 1'b0, 8'h00, 1'b1, 8'h00);
        acc(1'b0, 8'h25, 1'b0, 8'h00, 1'b1, 8'h9C);
        acc(1'b1, 8'h07, 1'b1, 8'hCD, 1'b1, 8'h00);
        acc(1'b1, 8'h04, 1'b0, 8'h00, 1'b1, 8'h70);
        acc(1'b1, 8'h05, 1'b0, 8'h00, 1'b1, 8'h02);
        conv(12'sh258, 10'h1FF);
        conv(-12'sh001, 10'h3FF);
        conv(-12'sh2BC, 10'h200);
        $display("diff test done");
    endtask
    task automatic t_se;
        acc(1'b1, 8'h07, 1'b1, 8'h40, 1'b1, 8'h00);
        @(negedge sys_clk);
        chk(active_diff_mode, 1'b0);
        conv(12'h000, 10'h000);
        conv(12'h3FF, 10'h3FF);
        conv(12'h5DC, 10'h3FF);
        $display("single test done");
    endtask
    task automatic t_hold;
        conv_busy = 1'b1;
        repeat (2) @(negedge sys_clk);
        acc(1'b1, 8'h07, 1'b1, 8'hE3, 1'b1, 8'h00);
        acc(1'b1, 8'h05, 1'b0, 8'h00, 1'b1, 8'hFF);
        chk(active_channel_sel, 5'h00);
        chk(active_ref_sel, 2'h1);
        conv(12'h010, 10'h010);
        chk(active_channel_sel, 5'h03);
        chk(active_ref_sel, 2'h3);
        $display("hold test done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        t_regs();
        t_diff();
        t_se();
        t_hold();
        summarize();
    end
    // whole run needs under a hundred cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            summarize();
        end
    end
endmodule
`default_nettype wire

// file: hw/arf_code_fmt.sv
// converts a raw signed sample into the 10-bit result code, single-ended or differential
`timescale 1ns/1ps
`include "arf_map.svh"
`default_nettype none
module arf_code_fmt
    import arf_pkg::*;
(
    input wire logic diff_mode,
    input wire logic signed [11:0] raw_sample,
    output logic [9:0] code
);
    always_comb begin
        if (diff_mode) begin
            // saturate to the two's complement range
            if (raw_sample > 12'sd511) begin
                code = `ARF_DIFF_POS_MAX;
            end else if (raw_sample < -12'sd512) begin
                code = `ARF_DIFF_NEG_MIN;
            end else begin
                code = raw_sample[9:0];
            end
        end else begin
            if (raw_sample < 12'sd0) begin
                code = 10'h000;
            end else if (raw_sample > 12'sd1023) begin
                code = `ARF_SE_MAX;
            end else begin
                code = raw_sample[9:0];
            end
        end
    end
endmodule
`default_nettype wire

// file: hw/arf_map.svh
// register offsets, field positions, reset values and codes for the converter result block
`ifndef ARF_MAP_SVH
`define ARF_MAP_SVH
`define ARF_IO_SEL_OFS 6'h07
`define ARF_IO_RES_LO_OFS 6'h04
`define ARF_IO_RES_HI_OFS 6'h05
`define ARF_DATA_IO_BASE 8'h20
`define ARF_DATA_EXT_BASE 8'h60
`define ARF_SEL_RESET 8'h00
`define ARF_SEL_REF_HI 7
`define ARF_SEL_REF_LO 6
`define ARF_SEL_LADJ 5
`define ARF_SEL_CH_HI 4
`define ARF_SEL_CH_LO 0
`define ARF_DIFF_FIRST 5'h08
`define ARF_DIFF_LAST 5'h1D
`define ARF_SE_MAX 10'h3FF
`define ARF_DIFF_POS_MAX 10'h1FF
`define ARF_DIFF_NEG_MIN 10'h200
`endif

// file: hw/arf_pkg.sv
// types for the converter result formatting block
package arf_pkg;
    typedef enum logic [1:0] {
        ARF_REF_EXT_PIN,
        ARF_REF_ANALOG_SUPPLY,
        ARF_REF_RESERVED,
        ARF_REF_INTERNAL
    } arf_ref_e;
    typedef struct packed {
        logic [1:0] ref_sel;
        logic left_adjust_result;
        logic [4:0] channel_gain_select;
    } arf_sel_s;
    typedef struct packed {
        logic [7:0] result_high_byte;
        logic [7:0] result_low_byte;
    } arf_pair_s;
endpackage

// file: hw/arf_result_block.sv
// input-selection register and result byte pair of the converter
// ==========================================================
`timescale 1ns/1ps
`include "arf_map.svh"
`default_nettype none
module arf_result_block
    import arf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic io_space,
    input wire logic [7:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic bus_hit,
    input wire logic conv_busy,
    input wire logic conv_done,
    input wire logic signed [11:0] conv_raw,
    output logic conversion_done_flag,
    output logic [1:0] active_ref_sel,
    output logic [4:0] active_channel_sel,
    output logic active_diff_mode,
    output logic [9:0] result_code
);
    // ==========================================================
    // address decode
    logic [5:0] io_ofs;
    logic in_io;
    logic sel_hit;
    logic lo_hit;
    logic hi_hit;
    always_comb begin
        // short form reaches only 0x00-0x3F; data form subtracts the 0x20 window
        io_ofs = 6'h00;
        in_io = 1'b0;
        if (io_space) begin
            io_ofs = bus_addr[5:0];
            in_io = (bus_addr[7:6] == 2'b00);
        end else if (bus_addr >= `ARF_DATA_IO_BASE && bus_addr < `ARF_DATA_EXT_BASE) begin
            io_ofs = 6'(bus_addr - `ARF_DATA_IO_BASE);
            in_io = 1'b1;
        end
        sel_hit = in_io && io_ofs == `ARF_IO_SEL_OFS;
        lo_hit = in_io && io_ofs == `ARF_IO_RES_LO_OFS;
        hi_hit = in_io && io_ofs == `ARF_IO_RES_HI_OFS;
    end

    // ==========================================================
    // selection register and the copy the converter uses
    arf_sel_s analog_input_select_r;
    arf_sel_s active_r;
    logic busy_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            analog_input_select_r <= `ARF_SEL_RESET;
        end else if (bus_wr && sel_hit) begin
            analog_input_select_r <= bus_wdata;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= conv_busy;
        end
    end
    // shadow copy: ref and channel freeze while busy, reload on completion
    // the shadow keeps no adjust bit: adjust is a read-time view and must not wait for a conversion
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            active_r <= `ARF_SEL_RESET;
        end else if (!conv_busy || conv_done) begin
            active_r.ref_sel <= analog_input_select_r.ref_sel;
            active_r.left_adjust_result <= 1'b0;
            active_r.channel_gain_select <= analog_input_select_r.channel_gain_select;
        end
    end

    // ==========================================================
    // reference decode
    // the reserved code is passed on as written so the converter side sees what software chose
    arf_ref_e ref_kind;
    always_comb begin
        case (active_r.ref_sel)
            2'h0: ref_kind = ARF_REF_EXT_PIN;
            2'h1: ref_kind = ARF_REF_ANALOG_SUPPLY;
            2'h3: ref_kind = ARF_REF_INTERNAL;
            default: ref_kind = ARF_REF_RESERVED;
        endcase
    end

    // ==========================================================
    // conversion capture
    logic diff_now;
    logic [9:0] fmt_code;
    logic [9:0] result_r;
    logic done_r;
    always_comb begin
        // channel codes 0x08-0x1D are differential pairs, including same-pin pairs
        diff_now = active_r.channel_gain_select >= `ARF_DIFF_FIRST
                   && active_r.channel_gain_select <= `ARF_DIFF_LAST;
    end
    arf_code_fmt u_fmt (
        .diff_mode(diff_now),
        .raw_sample(conv_raw),
        .code(fmt_code)
    );
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_r <= 10'h000;
        end else if (conv_done) begin
            result_r <= fmt_code;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_r <= 1'b0;
        end else if (conv_done) begin
            done_r <= 1'b1;
        end else if (conv_busy && !busy_q) begin
            done_r <= 1'b0;
        end
    end

    // ==========================================================
    // result pair presentation; adjust is applied at read time, not at capture
    arf_pair_s pair;
    always_comb begin
        if (analog_input_select_r.left_adjust_result) begin
            pair.result_high_byte = result_r[9:2];
            pair.result_low_byte = {result_r[1:0], 6'h00};
        end else begin
            pair.result_high_byte = {6'h00, result_r[9:8]};
            pair.result_low_byte = result_r[7:0];
        end
    end

    // ==========================================================
    // read port
    // writes to the result bytes answer but change nothing; only the selection register is writable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_hit <= 1'b0;
        end else begin
            bus_hit <= (bus_rd || bus_wr) && (sel_hit || lo_hit || hi_hit);
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd && sel_hit) begin
            bus_rdata <= analog_input_select_r;
        end else if (bus_rd && lo_hit) begin
            bus_rdata <= pair.result_low_byte;
        end else if (bus_rd && hi_hit) begin
            bus_rdata <= pair.result_high_byte;
        end else begin
            // idle reads zero so a missed decode never looks like data
            bus_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // registered status outputs
    // the flag lags done_r by one cycle so it rises together with result_code
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            conversion_done_flag <= 1'b0;
        end else begin
            conversion_done_flag <= done_r;
        end
    end
    // the byte pair is readable one cycle before this copy settles
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_code <= 10'h000;
        end else begin
            result_code <= result_r;
        end
    end

    // ==========================================================
    // registered copies of the selection the converter uses
    // one cycle behind the shadow, since every top output leaves a flip-flop
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            active_ref_sel <= 2'h0;
        end else begin
            active_ref_sel <= ref_kind;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            active_channel_sel <= 5'h00;
        end else begin
            active_channel_sel <= active_r.channel_gain_select;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            active_diff_mode <= 1'b0;
        end else begin
            active_diff_mode <= diff_now;
        end
    end
endmodule
`default_nettype wire
